// [logic/gsirq_pkg.sv]
//
// Contract
// RULE_01: overall busy bit 15 ORs three unit busies
// RULE_02: unit busy bits 7, 6, 5 follow units
// RULE_03: status bit 4 shows vertical blanking
// RULE_04: status bit 3 shows horizontal blanking
// RULE_05: bit 2 set on drop below watermark
// RULE_06: status bit 1 shows command queue full
// RULE_07: status bit 0 shows command queue empty
// RULE_08: status read-only, resets zero, 14-8 zero
// RULE_09: enables at 15, 7, 6, 5 gate interrupts
// RULE_10: blanking enables at bits 4 and 3
// RULE_11: queue enables at bits 2, 1, 0
// RULE_12: flag bit 15 ORs three completion flags
// RULE_13: completion flags sticky until software clears
// RULE_14: blanking entry sets sticky flags 4, 3
// RULE_15: watermark reach sets sticky flag 2; code sets it only on a drop from the level to below it
// RULE_16: full and empty entry set flags 1, 0
// RULE_17: first work area start is 24 bits
// RULE_18: second work area start is 24 bits
// RULE_19: software keeps work area starts even
// RULE_20: sync ports driven only when enabled
// RULE_21: five-bit watermark, zero disables event
// RULE_22: queue holds 16, full writes dropped
// RULE_23: interrupt when any flag and enable set
// RULE_24: write 0 clears flag, set wins
//
package gsirq_pkg;
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_IRQ_EN = 3'h1;
  localparam logic [2:0] IDX_FLAGS = 3'h2;
  localparam logic [2:0] IDX_WA1_LO = 3'h3;
  localparam logic [2:0] IDX_WA1_HI = 3'h4;
  localparam logic [2:0] IDX_WA2_LO = 3'h5;
  localparam logic [2:0] IDX_WA2_HI = 3'h6;
  localparam logic [2:0] IDX_CTRL = 3'h7;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_ANY = 15;
  localparam int BIT_DECOMP = 7;
  localparam int BIT_COPY = 6;
  localparam int BIT_TEXT = 5;
  localparam int BIT_VBLANK = 4;
  localparam int BIT_HBLANK = 3;
  localparam int BIT_WMK = 2;
  localparam int BIT_FULL = 1;
  localparam int BIT_EMPTY = 0;
  localparam int CTRL_HS_EN = 0;
  localparam int CTRL_VS_EN = 1;
  localparam int CTRL_WMK_LO = 8;
  localparam int WMK_W = 5;
  localparam int CNT_W = 5;
  localparam int CMD_FIFO_DEPTH = 16;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [15:0] IE_MASK = 16'h80ff;
  localparam logic [15:0] CTRL_MASK = 16'h1f03;
endpackage : gsirq_pkg

// [logic/gsirq_regs.sv]
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module gsirq_regs
  import gsirq_pkg::*;
#(
  parameter int DEPTH = CMD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WR_DATA,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  output logic [DATA_W-1:0] RD_DATA,
  // processing units
  input wire logic DECOMP_BUSY,
  input wire logic COPY_BUSY,
  input wire logic TEXT_BUSY,
  input wire logic DECOMP_DONE,
  input wire logic COPY_DONE,
  input wire logic TEXT_DONE,
  // display timing
  input wire logic VBLANK_IN,
  input wire logic HBLANK_IN,
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  output logic HSYNC_OUT,
  output logic HSYNC_OE,
  output logic VSYNC_OUT,
  output logic VSYNC_OE,
  // command queue
  input wire logic [CNT_W-1:0] CMD_COUNT,
  input wire logic CMD_PUSH,
  output logic CMD_ACCEPT,
  output logic [WMK_W-1:0] WMK_LEVEL,
  // work areas
  output logic [23:0] WA1_START,
  output logic [23:0] WA2_START,
  // interrupt
  output logic GFX_IRQ
);

  // ----------------------------------------
  // decode helper
  // ----------------------------------------

  // strobe aimed at one register index
  function automatic logic hit(
    input logic strobe,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] idx
  );
    hit = strobe && (a == idx);
  endfunction : hit

  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------

  logic rst_meta_q; // first stage, read only by second
  logic rst_n; // released copy used below

  // async assert, clocked release
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // write strobes
  // ----------------------------------------

  logic wr_ie;
  logic wr_flags;
  logic wr_wa1_lo;
  logic wr_wa1_hi;
  logic wr_wa2_lo;
  logic wr_wa2_hi;
  logic wr_ctrl;

  assign wr_ie = hit(WR_STROBE, ADDR, IDX_IRQ_EN);
  assign wr_flags = hit(WR_STROBE, ADDR, IDX_FLAGS);
  assign wr_wa1_lo = hit(WR_STROBE, ADDR, IDX_WA1_LO);
  assign wr_wa1_hi = hit(WR_STROBE, ADDR, IDX_WA1_HI);
  assign wr_wa2_lo = hit(WR_STROBE, ADDR, IDX_WA2_LO);
  assign wr_wa2_hi = hit(WR_STROBE, ADDR, IDX_WA2_HI);
  assign wr_ctrl = hit(WR_STROBE, ADDR, IDX_CTRL);

  // ----------------------------------------
  // control and enable registers
  // ----------------------------------------

  logic [15:0] ie_q; // interrupt enables
  logic [15:0] ctrl_q; // sync enables, watermark
  logic [WMK_W-1:0] wmk; // watermark level
  logic hs_en; // hsync port enable
  logic vs_en; // vsync port enable

  // only implemented enable bits store
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= RST_WORD;
    end else if (wr_ie) begin
      ie_q <= WR_DATA & IE_MASK; // [RULE_09] [RULE_10] [RULE_11]
    end
  end

  // control word for sync ports and watermark
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= RST_WORD;
    end else if (wr_ctrl) begin
      ctrl_q <= WR_DATA & CTRL_MASK;
    end
  end

  assign wmk = ctrl_q[CTRL_WMK_LO +: WMK_W]; // [RULE_21]
  assign hs_en = ctrl_q[CTRL_HS_EN];
  assign vs_en = ctrl_q[CTRL_VS_EN];
  assign WMK_LEVEL = wmk;

  // ----------------------------------------
  // work area start addresses
  // ----------------------------------------

  logic [23:0] wa1_q;
  logic [23:0] wa2_q;

  // low word and high byte written apart
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wa1_q <= 24'h000000;
    end else if (wr_wa1_lo) begin
      wa1_q[15:0] <= WR_DATA; // [RULE_17]
    end else if (wr_wa1_hi) begin
      wa1_q[23:16] <= WR_DATA[7:0]; // [RULE_17]
    end
  end

  // second area, same split
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wa2_q <= 24'h000000;
    end else if (wr_wa2_lo) begin
      wa2_q[15:0] <= WR_DATA; // [RULE_18]
    end else if (wr_wa2_hi) begin
      wa2_q[23:16] <= WR_DATA[7:0]; // [RULE_18]
    end
  end

  // bit 0 passed as stored; odd values are software's fault
  assign WA1_START = wa1_q; // [RULE_19]
  assign WA2_START = wa2_q;

  // ----------------------------------------
  // command queue status
  // ----------------------------------------

  logic [CNT_W-1:0] cnt_prev_q; // count one cycle ago
  logic full_prev_q;
  logic empty_prev_q;
  logic below_q; // below-watermark status
  logic q_full;
  logic q_empty;
  logic wmk_evt;

  assign q_full = (CMD_COUNT == CNT_W'(DEPTH)); // [RULE_06] [RULE_22]
  assign q_empty = (CMD_COUNT == '0); // [RULE_07]

  // drop from exactly the level to below it
  assign wmk_evt = (wmk != '0) && (cnt_prev_q == wmk) && (CMD_COUNT < wmk); // [RULE_21]

  // previous values for edge detection
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_prev_q <= '0;
      full_prev_q <= 1'b0;
      empty_prev_q <= 1'b1; // empty at reset is no new event
    end else begin
      cnt_prev_q <= CMD_COUNT;
      full_prev_q <= q_full;
      empty_prev_q <= q_empty;
    end
  end

  // set by the drop, cleared once back at level
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      below_q <= 1'b0;
    end else if (wmk_evt) begin
      below_q <= 1'b1; // [RULE_05]
    end else if (wmk == '0 || CMD_COUNT >= wmk) begin
      below_q <= 1'b0; // [RULE_05] [RULE_21]
    end
  end

  // pushes into a full queue are dropped
  assign CMD_ACCEPT = CMD_PUSH && !q_full; // [RULE_22]

  // ----------------------------------------
  // blanking edges
  // ----------------------------------------

  logic vb_prev_q;
  logic hb_prev_q;

  // entry into blanking is the event
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      vb_prev_q <= 1'b0;
      hb_prev_q <= 1'b0;
    end else begin
      vb_prev_q <= VBLANK_IN;
      hb_prev_q <= HBLANK_IN;
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------

  logic [7:0] hw_set; // per-bit set events
  logic [7:0] flags_q; // sticky flags 7..0
  logic [15:0] flags_rd; // flag word as read
  logic [15:0] status_w; // status word as read

  assign hw_set[BIT_DECOMP] = DECOMP_DONE; // [RULE_13]
  assign hw_set[BIT_COPY] = COPY_DONE; // [RULE_13]
  assign hw_set[BIT_TEXT] = TEXT_DONE; // [RULE_13]
  assign hw_set[BIT_VBLANK] = VBLANK_IN && !vb_prev_q; // [RULE_14]
  assign hw_set[BIT_HBLANK] = HBLANK_IN && !hb_prev_q; // [RULE_14]
  assign hw_set[BIT_WMK] = wmk_evt; // [RULE_15]
  assign hw_set[BIT_FULL] = q_full && !full_prev_q; // [RULE_16]
  assign hw_set[BIT_EMPTY] = q_empty && !empty_prev_q; // [RULE_16]

  // one sticky flag per bit; writing 1 leaves it alone
  for (genvar i = 0; i < 8; i++) begin : g_flag
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        flags_q[i] <= RST_FLAGS[i];
      end else if (hw_set[i]) begin
        flags_q[i] <= 1'b1; // [RULE_24] set beats clear
      end else if (wr_flags && !WR_DATA[i]) begin
        flags_q[i] <= 1'b0; // [RULE_24]
      end
    end
  end

  // bit 15 is derived, never stored
  always_comb begin
    flags_rd = RST_WORD;
    flags_rd[7:0] = flags_q;
    flags_rd[BIT_ANY] = |flags_q[BIT_DECOMP:BIT_TEXT]; // [RULE_12]
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------

  // live view; unused bits stay zero
  always_comb begin
    status_w = RST_WORD; // [RULE_08]
    status_w[BIT_DECOMP] = DECOMP_BUSY; // [RULE_02]
    status_w[BIT_COPY] = COPY_BUSY; // [RULE_02]
    status_w[BIT_TEXT] = TEXT_BUSY; // [RULE_02]
    status_w[BIT_ANY] = DECOMP_BUSY | COPY_BUSY | TEXT_BUSY; // [RULE_01]
    status_w[BIT_VBLANK] = VBLANK_IN; // [RULE_03]
    status_w[BIT_HBLANK] = HBLANK_IN; // [RULE_04]
    status_w[BIT_WMK] = below_q; // [RULE_05]
    status_w[BIT_FULL] = q_full; // [RULE_06]
    status_w[BIT_EMPTY] = q_empty; // [RULE_07]
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------

  logic [15:0] rd_d;

  // status ignores writes: no strobe for it exists
  always_comb begin
    case (ADDR)
      IDX_STATUS: rd_d = status_w; // [RULE_08]
      IDX_IRQ_EN: rd_d = ie_q;
      IDX_FLAGS: rd_d = flags_rd;
      IDX_WA1_LO: rd_d = wa1_q[15:0];
      IDX_WA1_HI: rd_d = {8'h00, wa1_q[23:16]}; // [RULE_17]
      IDX_WA2_LO: rd_d = wa2_q[15:0];
      IDX_WA2_HI: rd_d = {8'h00, wa2_q[23:16]}; // [RULE_18]
      IDX_CTRL: rd_d = ctrl_q;
      default: rd_d = RST_WORD;
    endcase
  end

  // data only in the cycle after the strobe
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA <= RST_WORD;
    end else if (RD_STROBE) begin
      RD_DATA <= rd_d;
    end else begin
      RD_DATA <= RST_WORD;
    end
  end

  // ----------------------------------------
  // sync ports and interrupt
  // ----------------------------------------

  // sync levels pass through one flop when enabled
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HSYNC_OUT <= 1'b0;
      VSYNC_OUT <= 1'b0;
    end else begin
      HSYNC_OUT <= HSYNC_IN && hs_en; // [RULE_20]
      VSYNC_OUT <= VSYNC_IN && vs_en; // [RULE_20]
    end
  end

  assign HSYNC_OE = hs_en; // [RULE_20]
  assign VSYNC_OE = vs_en; // [RULE_20]

  // registered so the line never glitches
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      GFX_IRQ <= 1'b0;
    end else begin
      GFX_IRQ <= |(flags_rd & ie_q); // [RULE_23] [RULE_09]
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------

  a_busy_any: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_01]
    hit(RD_STROBE, ADDR, IDX_STATUS) |=>
      RD_DATA[BIT_ANY] == $past(DECOMP_BUSY | COPY_BUSY | TEXT_BUSY))
    else $error("busy summary wrong");

  a_status_gap: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_08]
    hit(RD_STROBE, ADDR, IDX_STATUS) |=> RD_DATA[14:8] == 7'h00)
    else $error("status gap not zero");

  a_full_read: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_06]
    hit(RD_STROBE, ADDR, IDX_STATUS) |=>
      RD_DATA[BIT_FULL] == $past(CMD_COUNT == CNT_W'(DEPTH)))
    else $error("full status wrong");

  a_vblank_entry: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_14]
    $rose(VBLANK_IN) |=> flags_q[BIT_VBLANK])
    else $error("vblank flag not set");

  a_set_wins: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_24]
    DECOMP_DONE && wr_flags && !WR_DATA[BIT_DECOMP] |=> flags_q[BIT_DECOMP])
    else $error("clear beat set");

  a_flag_sticky: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_13]
    flags_q[BIT_COPY] && !(wr_flags && !WR_DATA[BIT_COPY]) |=> flags_q[BIT_COPY])
    else $error("flag lost");

  a_irq_masked: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_23]
    ie_q == RST_WORD |=> !GFX_IRQ)
    else $error("irq with no enable");

  a_wa_high_zero: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_17]
    hit(RD_STROBE, ADDR, IDX_WA1_HI) |=> RD_DATA[15:8] == 8'h00)
    else $error("high byte not zero");

  a_hsync_off: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_20]
    !hs_en |-> !HSYNC_OE ##1 !HSYNC_OUT)
    else $error("hsync driven while off");

  a_full_drop: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_22]
    q_full |-> !CMD_ACCEPT)
    else $error("push taken while full");

  a_wmk_off: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_21]
    wmk == '0 |-> !hw_set[BIT_WMK] ##1 !below_q)
    else $error("watermark active when off");

endmodule : gsirq_regs

// [verif/gsirq_regs_tb.sv]
`timescale 1ns/1ps
module gsirq_regs_tb;
  import gsirq_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [DATA_W-1:0] wr_data = 16'h0000;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [DATA_W-1:0] rd_data;
  // unit busy and done lines
  logic dec_busy = 1'b0, copy_busy = 1'b0, text_busy = 1'b0;
  logic dec_done = 1'b0, copy_done = 1'b0, text_done = 1'b0;
  // display timing lines
  logic vblank = 1'b0, hblank = 1'b0, hsync_in = 1'b0, vsync_in = 1'b0;
  logic hsync_out, hsync_oe, vsync_out, vsync_oe;
  // count starts at one so the status word reads all zero after reset
  logic [CNT_W-1:0] cmd_count = 5'h01;
  logic cmd_push = 1'b0;
  logic cmd_accept;
  logic [WMK_W-1:0] wmk_level;
  logic [23:0] wa1_start, wa2_start;
  logic gfx_irq;
  int fails = 0;
  int checks_done = 0;

  // 25 MHz system clock
  always #20 clk = ~clk;

  gsirq_regs #(.DEPTH(CMD_FIFO_DEPTH)) dut_u (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_STROBE(wr_strobe),
    .RD_STROBE(rd_strobe), .RD_DATA(rd_data), .DECOMP_BUSY(dec_busy), .COPY_BUSY(copy_busy),
    .TEXT_BUSY(text_busy), .DECOMP_DONE(dec_done), .COPY_DONE(copy_done), .TEXT_DONE(text_done),
    .VBLANK_IN(vblank), .HBLANK_IN(hblank), .HSYNC_IN(hsync_in), .VSYNC_IN(vsync_in),
    .HSYNC_OUT(hsync_out), .HSYNC_OE(hsync_oe), .VSYNC_OUT(vsync_out), .VSYNC_OE(vsync_oe),
    .CMD_COUNT(cmd_count), .CMD_PUSH(cmd_push), .CMD_ACCEPT(cmd_accept), .WMK_LEVEL(wmk_level),
    .WA1_START(wa1_start), .WA2_START(wa2_start), .GFX_IRQ(gfx_irq)
  );

  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  // words and addresses, zero-extended to 24 bits
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : chk_word

  // single output lines
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: line %b, wanted %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    chk_word({8'h00, rd_data}, {8'h00, exp});
  endtask : rd_chk

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every register reads zero straight after reset, outputs idle
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd_chk(i[2:0], 16'h0000);
    end
    @(posedge clk);
    #1;
    chk_word({8'h00, rd_data}, 24'h000000);
    chk_bit(gfx_irq, 1'b0);
    chk_bit(hsync_oe, 1'b0);
    chk_bit(vsync_oe, 1'b0);
  endtask : t_reset

  // live status bits against every busy mix, vblank following text busy and hblank copy busy
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {dec_busy, copy_busy, text_busy} <= i[2:0];
      vblank <= i[0];
      hblank <= i[1];
      rd_chk(3'h0, {|i[2:0], 7'h00, i[2:0], i[0], i[1], 3'b000});
    end
    @(posedge clk);
    {dec_busy, copy_busy, text_busy, vblank, hblank} <= 5'h00;
    cmd_count <= 5'h10;
    rd_chk(3'h0, 16'h0002);
    @(posedge clk);
    cmd_count <= 5'h00;
    rd_chk(3'h0, 16'h0001);
    // writes to the status word must not land anywhere
    wr(3'h0, 16'hffff);
    rd_chk(3'h0, 16'h0001);
    // watermark four: drop from four to three, then climb back
    wr(3'h7, 16'h0400);
    cmd_count <= 5'h04;
    cyc(2);
    cmd_count <= 5'h03;
    rd_chk(3'h0, 16'h0004);
    chk_word({19'h0, wmk_level}, 24'h000004);
    @(posedge clk);
    cmd_count <= 5'h04;
    cyc(2);
    rd_chk(3'h0, 16'h0000);
    wr(3'h7, 16'h0000);
    cmd_count <= 5'h01;
  endtask : t_status

  // unused enable bits stay zero
  task automatic t_enable();
    wr(3'h1, 16'hffff);
    rd_chk(3'h1, 16'h80ff);
  endtask : t_enable

  // each flag: arm, clear, fire its event, expect it alone (bits 7-5 also with bit 15), clear it
  task automatic t_flags();
    for (int b = 7; b >= 0; b--) begin
      @(posedge clk);
      vblank <= 1'b0;
      hblank <= 1'b0;
      if (b == 1) cmd_count <= 5'h0f;
      if (b == 2) cmd_count <= 5'h04;
      if (b == 2) wr(3'h7, 16'h0400);
      cyc(2);
      wr(3'h2, 16'h0000);
      rd_chk(3'h2, 16'h0000);
      @(posedge clk);
      case (b)
        7: dec_done <= 1'b1;
        6: copy_done <= 1'b1;
        5: text_done <= 1'b1;
        4: vblank <= 1'b1;
        3: hblank <= 1'b1;
        2: cmd_count <= 5'h03;
        1: cmd_count <= 5'h10;
        default: cmd_count <= 5'h00;
      endcase
      @(posedge clk);
      {dec_done, copy_done, text_done} <= 3'b000;
      cyc(2);
      rd_chk(3'h2, (16'h0001 << b) | ((b >= 5) ? 16'h8000 : 16'h0000));
      chk_bit(gfx_irq, 1'b1);
      wr(3'h2, 16'h0000);
      rd_chk(3'h2, 16'h0000);
      chk_bit(gfx_irq, 1'b0);
      wr(3'h7, 16'h0000);
      cmd_count <= 5'h01;
    end
  endtask : t_flags

  // hardware set beats a clear in the same cycle; ones never set
  task automatic t_setwins();
    @(posedge clk);
    addr <= 3'h2;
    wr_data <= 16'h0000;
    wr_strobe <= 1'b1;
    dec_done <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    dec_done <= 1'b0;
    rd_chk(3'h2, 16'h8080);
    wr(3'h2, 16'h0000);
    wr(3'h2, 16'hffff);
    rd_chk(3'h2, 16'h0000);
  endtask : t_setwins

  // a flag without its enable raises nothing; bit 15 enable alone does
  task automatic t_gating();
    wr(3'h1, 16'h0040);
    @(posedge clk);
    dec_done <= 1'b1;
    @(posedge clk);
    dec_done <= 1'b0;
    cyc(3);
    #1;
    chk_bit(gfx_irq, 1'b0);
    wr(3'h1, 16'h0080);
    cyc(2);
    #1;
    chk_bit(gfx_irq, 1'b1);
    wr(3'h1, 16'h8000);
    cyc(2);
    #1;
    chk_bit(gfx_irq, 1'b1);
    wr(3'h2, 16'h0000);
    cyc(2);
    #1;
    chk_bit(gfx_irq, 1'b0);
  endtask : t_gating

  // even starts only; upper byte of each high word reads zero
  task automatic t_work();
    wr(3'h3, 16'hbeee);
    wr(3'h4, 16'hff5a);
    wr(3'h5, 16'h1234);
    wr(3'h6, 16'h80c3);
    rd_chk(3'h3, 16'hbeee);
    rd_chk(3'h4, 16'h005a);
    rd_chk(3'h5, 16'h1234);
    rd_chk(3'h6, 16'h00c3);
    chk_word(wa1_start, 24'h5abeee);
    chk_word(wa2_start, 24'hc31234);
  endtask : t_work

  // each sync port follows only its own enable bit
  task automatic t_sync();
    @(posedge clk);
    hsync_in <= 1'b1;
    vsync_in <= 1'b1;
    for (int i = 1; i < 3; i++) begin
      wr(3'h7, i[15:0]);
      cyc(2);
      #1;
      chk_bit(hsync_oe, i[0]);
      chk_bit(hsync_out, i[0]);
      chk_bit(vsync_oe, i[1]);
      chk_bit(vsync_out, i[1]);
    end
    wr(3'h7, 16'hffff);
    rd_chk(3'h7, 16'h1f03);
    chk_word({19'h0, wmk_level}, 24'h00001f);
    wr(3'h7, 16'h0000);
  endtask : t_sync

  // a push into a full queue is dropped, one below full is taken
  task automatic t_queue();
    @(posedge clk);
    cmd_count <= 5'h10;
    cmd_push <= 1'b1;
    #1;
    chk_bit(cmd_accept, 1'b0);
    @(posedge clk);
    cmd_count <= 5'h0f;
    #1;
    chk_bit(cmd_accept, 1'b1);
    @(posedge clk);
    cmd_push <= 1'b0;
    cmd_count <= 5'h01;
  endtask : t_queue

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // synchroniser needs two edges before the first request
    cyc(4);
    t_reset();
    t_status();
    t_enable();
    t_flags();
    t_setwins();
    t_gating();
    t_work();
    t_sync();
    t_queue();
    tally_and_finish();
  end
endmodule : gsirq_regs_tb
